// File: clkdiv_cfg_pkg.sv
// package for the reference clock divider configuration block
// assumes a single 200 MHz system clock domain
`default_nettype none
package clkdiv_cfg_pkg;
    localparam int DIV_W = 10;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    // program register indices within the clock block
    localparam logic [2:0] IDX_IDLE_TIMER = 3'h2;
    localparam logic [2:0] IDX_IDLE_VCO = 3'h3;
    localparam logic [2:0] IDX_RXTX_REF = 3'h4;
    localparam logic [2:0] IDX_RXTX_PLL = 3'h5;
    localparam logic [2:0] IDX_RXTX_VCO = 3'h6;
    localparam logic [2:0] IDX_RXTX_CONV = 3'h7;
    // defaults for a 6.144 MHz reference
    localparam logic [9:0] RST_IDLE_TIMER = 10'h018;
    localparam logic [9:0] RST_IDLE_VCO = 10'h088;
    localparam logic [9:0] RST_RXTX_REF = 10'h040;
    localparam logic [9:0] RST_RXTX_PLL = 10'h200;
    localparam logic [9:0] RST_RXTX_VCO = 10'h140;
    localparam logic [9:0] RST_RXTX_CONV = 10'h008;
    // latency between a write and it being acted on
    localparam int LATENCY_US = 250;
    localparam int CLK_MHZ = 200;
    localparam int LATENCY_CYC = LATENCY_US * CLK_MHZ;
    localparam int LAT_W = 16;
endpackage : clkdiv_cfg_pkg
`default_nettype wire

// File: div_cfg_slot.sv
// one ten-bit divider setting: staging value and live value
// assumes load and apply strobes synchronous to sys_clk
`default_nettype none
module div_cfg_slot #(
    parameter int W = 10,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,      // system clock
    input wire logic rst_sync_n,   // synchronised reset
    input wire logic load,         // take new staging value
    input wire logic [W-1:0] din,  // new value, already trimmed
    input wire logic apply,        // copy staging to live
    output logic [W-1:0] live      // value the divider uses
);
    typedef struct packed {
        logic [W-1:0] stage;
        logic [W-1:0] live;
    } slot_state_t;
    slot_state_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.stage = din;
        end
        // a load in the apply cycle goes straight through
        if (apply) begin
            nxt_st.live = load ? din : st_ff.stage;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_ff <= '{stage: RST_VAL, live: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign live = st_ff.live;
endmodule // div_cfg_slot
`default_nettype wire

// File: reference_clock_divider_config.sv
// divider configuration registers for the device clock tree
// assumes writes arrive decoded from the serial control port, synchronous to sys_clk
// Function
// - reset leaves every divider at 6.144MHz default
// - only low ten bits stored
// - idle pair applied on idle vco write
// - rx/tx dividers applied on rx/tx entry
// - idle defaults 018 and 088
// - rx/tx defaults 040, 200, 140, 008
// - writes acted on within 250 us
`default_nettype none
module reference_clock_divider_config
    import clkdiv_cfg_pkg::*;
#(
    parameter int LAT_CYC = LATENCY_CYC
) (
    input wire logic sys_clk,                    // 200 MHz clock
    input wire logic rst_n,                      // async reset, active low
    input wire logic wr_en,                      // register write strobe
    input wire logic [ADDR_W-1:0] wr_idx,        // program register index
    input wire logic [DATA_W-1:0] wr_data,       // write data
    input wire logic rxtx_enter,                 // pulse on change into rx or tx
    output logic wr_busy,                        // latency window open
    output logic [DIV_W-1:0] idle_timer_div,     // live idle timer divide
    output logic [DIV_W-1:0] idle_vco_aux_div,   // live idle vco/aux divide
    output logic [DIV_W-1:0] rxtx_ref_div,       // live rx/tx reference divide
    output logic [DIV_W-1:0] rxtx_pll_div,       // live rx/tx pll divide
    output logic [DIV_W-1:0] rxtx_vco_aux_div,   // live rx/tx vco/aux divide
    output logic [DIV_W-1:0] rxtx_conv_div       // live converter clock divide
);
    // ==========================================================
    // reset release
    logic [1:0] rst_sync_ff;
    logic rst_sync_n;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_sync_ff[1];

    // ==========================================================
    // write capture, held until the latency window closes
    typedef struct packed {
        logic pend;
        logic [ADDR_W-1:0] idx;
        logic [DIV_W-1:0] data;
        logic [LAT_W-1:0] cnt;
    } ctl_state_t;
    ctl_state_t st_ff, nxt_st;
    logic act;

    // acting at the window end models the polled register read
    assign act = st_ff.pend && (st_ff.cnt == LAT_W'(LAT_CYC - 1));

    always_comb begin
        nxt_st = st_ff;
        if (st_ff.pend) begin
            nxt_st.cnt = st_ff.cnt + 1'b1;
        end
        if (act) begin
            nxt_st.pend = 1'b0;
            nxt_st.cnt = '0;
        end
        // a later write replaces a pending one; host should not do this
        if (wr_en) begin
            nxt_st.pend = 1'b1;
            nxt_st.idx = wr_idx;
            nxt_st.data = wr_data[DIV_W-1:0];
            nxt_st.cnt = '0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wr_busy = st_ff.pend;

    // ==========================================================
    // divider slots
    logic [5:0] ld;
    logic idle_apply;
    logic rxtx_apply;
    always_comb begin
        ld = '0;
        if (act) begin
            case (st_ff.idx)
                IDX_IDLE_TIMER: ld[0] = 1'b1;
                IDX_IDLE_VCO: ld[1] = 1'b1;
                IDX_RXTX_REF: ld[2] = 1'b1;
                IDX_RXTX_PLL: ld[3] = 1'b1;
                IDX_RXTX_VCO: ld[4] = 1'b1;
                IDX_RXTX_CONV: ld[5] = 1'b1;
                default: ld = '0;
            endcase
        end
    end
    assign idle_apply = ld[1];
    assign rxtx_apply = rxtx_enter;

    // defaults give correct operation from a 6.144 MHz reference
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_IDLE_TIMER)) u_idle_timer (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[0]),
        .din(st_ff.data),
        .apply(idle_apply),
        .live(idle_timer_div)
    );
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_IDLE_VCO)) u_idle_vco (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[1]),
        .din(st_ff.data),
        .apply(idle_apply),
        .live(idle_vco_aux_div)
    );
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_RXTX_REF)) u_rxtx_ref (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[2]),
        .din(st_ff.data),
        .apply(rxtx_apply),
        .live(rxtx_ref_div)
    );
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_RXTX_PLL)) u_rxtx_pll (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[3]),
        .din(st_ff.data),
        .apply(rxtx_apply),
        .live(rxtx_pll_div)
    );
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_RXTX_VCO)) u_rxtx_vco (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[4]),
        .din(st_ff.data),
        .apply(rxtx_apply),
        .live(rxtx_vco_aux_div)
    );
    div_cfg_slot #(.W(DIV_W), .RST_VAL(RST_RXTX_CONV)) u_rxtx_conv (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_n),
        .load(ld[5]),
        .din(st_ff.data),
        .apply(rxtx_apply),
        .live(rxtx_conv_div)
    );

    // ==========================================================
    // checks
    chk_reset_defaults: assert property (@(posedge sys_clk)
        $rose(rst_sync_n) |-> idle_timer_div == RST_IDLE_TIMER && idle_vco_aux_div == RST_IDLE_VCO
        && rxtx_ref_div == RST_RXTX_REF && rxtx_pll_div == RST_RXTX_PLL
        && rxtx_vco_aux_div == RST_RXTX_VCO && rxtx_conv_div == RST_RXTX_CONV)
        else $error("dividers not at defaults after reset");
    chk_reset_idle: assert property (@(posedge sys_clk)
        $rose(rst_sync_n) |-> !wr_busy)
        else $error("write window open after reset");

    chk_idle_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !ld[1] |=> $stable(idle_timer_div) && $stable(idle_vco_aux_div))
        else $error("idle divider changed without idle vco write");
    chk_idle_apply: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        ld[1] |=> idle_vco_aux_div == $past(st_ff.data))
        else $error("idle vco write not applied");

    chk_rxtx_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !rxtx_enter |=> $stable(rxtx_ref_div) && $stable(rxtx_pll_div)
        && $stable(rxtx_vco_aux_div) && $stable(rxtx_conv_div))
        else $error("rx/tx divider changed without mode entry");
    chk_rxtx_apply: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        ld[3] ##1 rxtx_enter |=> rxtx_pll_div == $past(st_ff.data, 2))
        else $error("pending pll divide not applied");
    chk_rxtx_direct: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        rxtx_enter && ld[2] |=> rxtx_ref_div == $past(st_ff.data))
        else $error("reference divide not applied on entry in acting cycle");
    chk_vco_apply: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        ld[4] ##1 rxtx_enter |=> rxtx_vco_aux_div == $past(st_ff.data, 2))
        else $error("pending rx/tx vco divide not applied");
    chk_conv_direct: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        rxtx_enter && ld[5] |=> rxtx_conv_div == $past(st_ff.data))
        else $error("converter divide not applied on entry in acting cycle");

    chk_trim_bits: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        wr_en |=> st_ff.data == $past(wr_data[DIV_W-1:0]))
        else $error("write data not trimmed to ten bits");

    chk_act_latency: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        act |-> $past(st_ff.pend) && st_ff.cnt == LAT_W'(LAT_CYC - 1))
        else $error("write acted on at wrong time");
    chk_busy_rise: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        wr_en |=> wr_busy)
        else $error("busy not raised after write");
    chk_busy_hold: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        wr_busy && !act |=> wr_busy)
        else $error("busy dropped before write acted on");
    chk_busy_fall: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        act && !wr_en |=> !wr_busy)
        else $error("busy held after write acted on");
    chk_busy_low: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !wr_busy && !wr_en |=> !wr_busy)
        else $error("busy raised without write");
    chk_cnt_restart: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        wr_en |=> st_ff.cnt == '0)
        else $error("latency count not restarted by write");

    // ==========================================================
    // scenario covers
    cov_idle_write: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) ld[1]);
    cov_rxtx_apply: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) ld[2] ##[1:20] rxtx_enter);
    cov_rewrite: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) wr_busy && wr_en);
    cov_rxtx_direct: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) ld[2] && rxtx_enter);
    cov_unused_idx: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) act && st_ff.idx < IDX_IDLE_TIMER);
endmodule // reference_clock_divider_config
`default_nettype wire

// File: host_model.sv
// host side model: issues program register writes toward the divider block
// assumes a caller in the sys_clk domain that spaces writes by the latency window
`default_nettype none
module host_model
    import clkdiv_cfg_pkg::*;
(
    input wire logic sys_clk,          // system clock
    output logic wr_en,                // write strobe
    output logic [ADDR_W-1:0] wr_idx,  // register index
    output logic [DATA_W-1:0] wr_data  // write data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_en = 1'b0;
        wr_idx = '0;
        wr_data = '0;
    end
    // =====================================
    // write
    // one-cycle strobe; bus inverted after so stale data never passes as valid
    task automatic put(input logic [ADDR_W-1:0] idx, input logic [DATA_W-1:0] data);
        @(posedge sys_clk);
        #1;
        wr_en = 1'b1;
        wr_idx = idx;
        wr_data = data;
        @(posedge sys_clk);
        #1;
        wr_en = 1'b0;
        wr_idx = ~idx;
        wr_data = ~data;
    endtask
endmodule // host_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the divider configuration block
// assumes the host model drives writes; latency shortened to 8 cycles
`default_nettype none
module testbench
    import clkdiv_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LAT = 8;
    localparam logic [59:0] DEF = {10'h018, 10'h088, 10'h040, 10'h200, 10'h140, 10'h008};
    // modelled reference, kept under the crystal limit
    localparam int REF_KHZ = 12000;
    localparam int XTAL_MAX_KHZ = 12288;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rxtx_enter = 1'b0;
    wire logic wr_en;
    wire logic [ADDR_W-1:0] wr_idx;
    wire logic [DATA_W-1:0] wr_data;
    wire logic wr_busy;
    wire logic [DIV_W-1:0] d0, d1, d2, d3, d4, d5;
    wire logic [59:0] all_div = {d0, d1, d2, d3, d4, d5};
    int n_mismatch = 0;
    int checks = 0;
    always #2.5 sys_clk = ~sys_clk;
    host_model host_model_i (.sys_clk(sys_clk), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data));
    reference_clock_divider_config #(.LAT_CYC(LAT)) reference_clock_divider_config_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data),
        .rxtx_enter(rxtx_enter), .wr_busy(wr_busy), .idle_timer_div(d0), .idle_vco_aux_div(d1),
        .rxtx_ref_div(d2), .rxtx_pll_div(d3), .rxtx_vco_aux_div(d4), .rxtx_conv_div(d5));
    // =====================================
    // helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // busy must last exactly the latency window
    task automatic wr(input logic [2:0] idx, input logic [15:0] data);
        int n;
        n = 0;
        host_model_i.put(idx, data);
        chk(64'(wr_busy), 64'h1);
        while (wr_busy !== 1'b0 && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n >= 40) begin
            n_mismatch++;
            wrap_up();
        end else chk(64'(n), 64'(LAT));
    endtask
    // write, then enter rx/tx; lag LAT-1 hits the acting cycle, LAT the cycle after
    task automatic wr_enter(input logic [2:0] idx, input logic [15:0] data, input int lag,
        input logic [59:0] exp);
        host_model_i.put(idx, data);
        repeat (lag) @(posedge sys_clk);
        #1 rxtx_enter = 1'b1;
        @(posedge sys_clk);
        #1 rxtx_enter = 1'b0;
        chk(64'(wr_busy), 64'h0);
        chk(64'(all_div), 64'(exp));
    endtask
    // =====================================
    // sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(64'(all_div), 64'(DEF));
        chk(64'(REF_KHZ <= XTAL_MAX_KHZ), 64'h1);
        wr(3'h2, 16'hfc17);
        chk(64'(all_div), 64'(DEF));
        wr(3'h3, 16'hf155);
        chk(64'(all_div), 64'({20'h05d55, DEF[39:0]}));
        wr(3'h4, 16'h807d);
        wr(3'h5, 16'h4300);
        wr(3'h6, 16'h2141);
        wr(3'h7, 16'h1009);
        wr(3'h0, 16'h03ff);
        wr(3'h1, 16'h03ff);
        chk(64'(all_div), 64'({20'h05d55, DEF[39:0]}));
        @(posedge sys_clk);
        #1 rxtx_enter = 1'b1;
        @(posedge sys_clk);
        #1 rxtx_enter = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(64'(all_div), 64'({20'h05d55, 10'h07d, 10'h300, 10'h141, 10'h009}));
        wr_enter(3'h4, 16'h00c8, LAT - 1, {20'h05d55, 10'h0c8, 10'h300, 10'h141, 10'h009});
        wr_enter(3'h5, 16'hc398, LAT, {20'h05d55, 10'h0c8, 10'h398, 10'h141, 10'h009});
        wr_enter(3'h6, 16'h0aaa, LAT, {20'h05d55, 10'h0c8, 10'h398, 10'h2aa, 10'h009});
        wr_enter(3'h7, 16'hfc10, LAT - 1, {20'h05d55, 10'h0c8, 10'h398, 10'h2aa, 10'h010});
        // reset in mid-run drops a staged value and a pending write
        wr(3'h6, 16'h0155);
        host_model_i.put(3'h4, 16'h0060);
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk(64'(wr_busy), 64'h0);
        chk(64'(all_div), 64'(DEF));
        rxtx_enter = 1'b1;
        @(posedge sys_clk);
        #1 rxtx_enter = 1'b0;
        chk(64'(all_div), 64'(DEF));
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
